// ===== hdl/trl_rate_limiter.sv
`timescale 1ns/10ps
`include "trl_regs.svh"

module trl_rate_limiter (
  input wire logic ref_clk, // Core clock, 250 MHz
  input wire logic rst, // Async reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic inValid, // Byte from queue system valid
  input wire logic [7:0] inData, // Byte from queue system
  input wire logic inSof, // First byte of frame
  input wire logic inEof, // Last byte of frame
  output logic inReady, // Byte taken when high with inValid
  output logic outValid, // Byte toward MAC valid
  output logic [7:0] outData, // Byte toward MAC
  output logic outSof, // First byte toward MAC
  output logic outEof, // Last byte toward MAC
  input wire logic cellOverflowEvt, // Cell buffer overflow pulse
  input wire logic cellUnderrunEvt // Cell buffer underrun pulse
);
  import trl_pkg::*;

  trl_state_reg_type st_reg;
  trl_state_reg_type st_next;

  // ----------------------------------------------------------------
  // Gap arithmetic
  // ----------------------------------------------------------------
  logic [15:0] acctLen;
  logic [34:0] payNum;
  logic [34:0] ratioSafe;
  logic [34:0] payQuo;
  logic [34:0] payRem;
  logic [23:0] ovhExtra;
  logic [23:0] payExtra;
  logic [23:0] frmExtra;
  logic [24:0] sumExtra;
  logic [23:0] maxExtra;
  logic [23:0] extraGap;
  logic [24:0] gapTotal;

  assign acctLen = st_reg.payLen + (st_reg.preamSel ?
    `TRL_PREAMBLE_BYTES : 16'h0000);
  assign payNum = ((35'(acctLen) << 8) << st_reg.scaleExp)
    + 35'(st_reg.fracCarry);
  assign ratioSafe = (st_reg.ratio == 19'h00000) ? 35'h000000001 :
    35'(st_reg.ratio);
  assign payQuo = payNum / ratioSafe;
  assign payRem = payNum % ratioSafe;
  assign ovhExtra = (st_reg.ovhEn && st_reg.fixedGap > `TRL_STD_GAP) ?
    (24'(st_reg.fixedGap - `TRL_STD_GAP) << st_reg.scaleExp) :
    24'h000000;
  assign payExtra = !st_reg.payEn ? 24'h000000 :
    (payQuo[34:24] != 11'h000) ? 24'hFFFFFF : payQuo[23:0];
  assign frmExtra = (st_reg.frmEn && st_reg.spacing > `TRL_SPACING_MIN)
    ? 24'(st_reg.spacing) : 24'h000000;
  assign sumExtra = 25'(ovhExtra) + 25'(payExtra);

  always_comb begin
    maxExtra = ovhExtra;
    if (payExtra > maxExtra) begin
      maxExtra = payExtra;
    end
    if (frmExtra > maxExtra) begin
      maxExtra = frmExtra;
    end
    if (st_reg.accumEn && st_reg.ovhEn && st_reg.payEn && !st_reg.frmEn)
    begin
      extraGap = sumExtra[24] ? 24'hFFFFFF : sumExtra[23:0];
    end else begin
      extraGap = maxExtra;
    end
  end

  // CALC cycle itself is the first gap cycle
  assign gapTotal = 25'(extraGap) + 25'(`TRL_STD_GAP)
    - 25'h0000001;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic busAccess;
  logic busWrite;
  logic accept;
  logic isPayload;
  logic [15:0] bytePos;
  logic [15:0] spacingBase;
  logic [31:0] readMux;
  logic mapped;

  always_comb begin
    st_next = st_reg;
    busAccess = psel && penable;
    busWrite = busAccess && pwrite && st_reg.pready;
    accept = inValid && st_reg.inReady;
    bytePos = inSof ? 16'h0000 : st_reg.byteCnt;
    isPayload = !st_reg.hdrSubEn ||
      (bytePos >= 16'(st_reg.hdrCount));
    if (inSof) begin
      spacingBase = (st_reg.preamSel &&
        st_reg.spacingStart > `TRL_PREAMBLE_BYTES) ?
        st_reg.spacingStart - `TRL_PREAMBLE_BYTES :
        (st_reg.preamSel ? 16'h0000 : st_reg.spacingStart);
    end else begin
      spacingBase = st_reg.spacing;
    end
    mapped = 1'b1;
    readMux = 32'h00000000;
    case (paddr)
      `TRL_MODE_OFS: begin
        readMux[`TRL_OVH_EN_BIT] = st_reg.ovhEn;
        readMux[`TRL_PAY_EN_BIT] = st_reg.payEn;
        readMux[`TRL_FRM_EN_BIT] = st_reg.frmEn;
        readMux[`TRL_ACCUM_BIT] = st_reg.accumEn;
        readMux[`TRL_PREAM_BIT] = st_reg.preamSel;
        readMux[`TRL_HDRSUB_BIT] = st_reg.hdrSubEn;
        readMux[`TRL_SCALE_MSB:`TRL_SCALE_LSB] = st_reg.scaleExp;
      end
      `TRL_HDR_OFS: readMux[7:0] = st_reg.hdrCount;
      `TRL_GAPCOMP_OFS: readMux[7:0] = st_reg.fixedGap;
      `TRL_RATIO_OFS: readMux[18:0] = st_reg.ratio;
      `TRL_START_OFS: readMux[15:0] = st_reg.spacingStart;
      `TRL_OVF_OFS: readMux[0] = st_reg.ovfFlag;
      `TRL_UDR_OFS: readMux[0] = st_reg.udrFlag;
      `TRL_STR_OFS: readMux[0] = st_reg.strFlag;
      `TRL_LASTGAP_OFS: readMux[23:0] = st_reg.lastExtra;
      default: mapped = 1'b0;
    endcase

    // ----------------------------------------------------------------
    // APB slave, one wait state
    // ----------------------------------------------------------------
    st_next.pready = busAccess && !st_reg.pready;
    st_next.pslverr = busAccess && !st_reg.pready && !mapped;
    st_next.prdata = (busAccess && !st_reg.pready && !pwrite) ?
      readMux : 32'h00000000;
    if (busWrite) begin
      case (paddr)
        `TRL_MODE_OFS: begin
          st_next.ovhEn = pwdata[`TRL_OVH_EN_BIT];
          st_next.payEn = pwdata[`TRL_PAY_EN_BIT];
          st_next.frmEn = pwdata[`TRL_FRM_EN_BIT];
          st_next.accumEn = pwdata[`TRL_ACCUM_BIT];
          st_next.preamSel = pwdata[`TRL_PREAM_BIT];
          st_next.hdrSubEn = pwdata[`TRL_HDRSUB_BIT];
          st_next.scaleExp = pwdata[`TRL_SCALE_MSB:`TRL_SCALE_LSB];
        end
        `TRL_HDR_OFS: st_next.hdrCount = pwdata[7:0];
        `TRL_GAPCOMP_OFS: st_next.fixedGap = pwdata[7:0];
        `TRL_RATIO_OFS: st_next.ratio = pwdata[18:0];
        `TRL_START_OFS: st_next.spacingStart = pwdata[15:0];
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // Sticky flags, set wins over clear
    // ----------------------------------------------------------------
    st_next.ovfFlag = cellOverflowEvt || (st_reg.ovfFlag &&
      !(busWrite && paddr == `TRL_OVF_OFS && pwdata[0]));
    st_next.udrFlag = cellUnderrunEvt || (st_reg.udrFlag &&
      !(busWrite && paddr == `TRL_UDR_OFS && pwdata[0]));
    st_next.strFlag = (st_reg.state == TRL_CALC &&
      extraGap != 24'h000000) || (st_reg.strFlag &&
      !(busWrite && paddr == `TRL_STR_OFS && pwdata[0]));

    // ----------------------------------------------------------------
    // Frame path and gap sequencing
    // ----------------------------------------------------------------
    st_next.outValid = accept;
    st_next.outData = accept ? inData : 8'h00;
    st_next.outSof = accept && inSof;
    st_next.outEof = accept && inEof;
    case (st_reg.state)
      TRL_PASS: begin
        if (accept) begin
          st_next.byteCnt = (bytePos == 16'hFFFF) ? bytePos :
            bytePos + 16'h0001;
          st_next.payLen = (inSof ? 16'h0000 : st_reg.payLen) +
            (isPayload ? 16'h0001 : 16'h0000);
          st_next.spacing = (isPayload && spacingBase != 16'h0000) ?
            spacingBase - 16'h0001 : spacingBase;
          if (inEof) begin
            st_next.state = TRL_CALC;
          end
        end
      end
      TRL_CALC: begin
        st_next.lastExtra = extraGap;
        if (st_reg.payEn) begin
          st_next.fracCarry = payRem[18:0];
        end
        st_next.gapCnt = gapTotal[24] ? 24'hFFFFFF : gapTotal[23:0];
        st_next.state = (gapTotal[23:0] == 24'h000000 && !gapTotal[24]) ?
          TRL_PASS : TRL_GAP;
      end
      TRL_GAP: begin
        if (st_reg.gapCnt <= 24'h000001) begin
          st_next.gapCnt = 24'h000000;
          st_next.state = TRL_PASS;
        end else begin
          st_next.gapCnt = st_reg.gapCnt - 24'h000001;
        end
      end
      default: st_next.state = TRL_PASS;
    endcase
    st_next.inReady = (st_next.state == TRL_PASS);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.hdrCount <= `TRL_HDR_RST;
      st_reg.fixedGap <= `TRL_GAPCOMP_RST;
      st_reg.ratio <= `TRL_RATIO_RST;
      st_reg.spacingStart <= `TRL_START_RST;
      st_reg.state <= TRL_PASS;
      st_reg.inReady <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign inReady = st_reg.inReady;
  assign outValid = st_reg.outValid;
  assign outData = st_reg.outData;
  assign outSof = st_reg.outSof;
  assign outEof = st_reg.outEof;

endmodule : trl_rate_limiter

// ===== hdl/trl_regs.svh
`ifndef TRL_REGS_SVH
`define TRL_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TRL_MODE_OFS 8'h00
`define TRL_HDR_OFS 8'h04
`define TRL_GAPCOMP_OFS 8'h08
`define TRL_RATIO_OFS 8'h0C
`define TRL_START_OFS 8'h10
`define TRL_OVF_OFS 8'h14
`define TRL_UDR_OFS 8'h18
`define TRL_STR_OFS 8'h1C
`define TRL_LASTGAP_OFS 8'h20

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define TRL_OVH_EN_BIT 0
`define TRL_PAY_EN_BIT 1
`define TRL_FRM_EN_BIT 2
`define TRL_ACCUM_BIT 3
`define TRL_PREAM_BIT 4
`define TRL_HDRSUB_BIT 5
`define TRL_SCALE_LSB 8
`define TRL_SCALE_MSB 11

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TRL_HDR_RST 8'h00
`define TRL_GAPCOMP_RST 8'h0D
`define TRL_RATIO_RST 19'h00480
`define TRL_START_RST 16'h0000

// ----------------------------------------------------------------
// Byte counts
// ----------------------------------------------------------------
`define TRL_STD_GAP 8'h0C
`define TRL_PREAMBLE_BYTES 16'h0008
`define TRL_SPACING_MIN 16'h000C

`endif

// ===== hdl/trl_pkg.sv
package trl_pkg;

  typedef enum logic [1:0] {
    TRL_PASS,
    TRL_CALC,
    TRL_GAP
  } trl_state_type;

  typedef struct packed {
    logic ovhEn;
    logic payEn;
    logic frmEn;
    logic accumEn;
    logic preamSel;
    logic hdrSubEn;
    logic [3:0] scaleExp;
    logic [7:0] hdrCount;
    logic [7:0] fixedGap;
    logic [18:0] ratio;
    logic [15:0] spacingStart;
    logic ovfFlag;
    logic udrFlag;
    logic strFlag;
    trl_state_type state;
    logic [15:0] byteCnt;
    logic [15:0] payLen;
    logic [15:0] spacing;
    logic [18:0] fracCarry;
    logic [23:0] gapCnt;
    logic [23:0] lastExtra;
    logic inReady;
    logic outValid;
    logic [7:0] outData;
    logic outSof;
    logic outEof;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } trl_state_reg_type;

endpackage : trl_pkg

// ===== verif/trl_checker.sv
`timescale 1ns/10ps
// ----
// Port checker
// ----
module trl_checker (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Wdata
  input wire logic [31:0] prdata, // Rdata
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic inValid, // In valid
  input wire logic [7:0] inData, // In byte
  input wire logic inSof, // In first
  input wire logic inEof, // In last
  input wire logic inReady, // In ready
  input wire logic outValid, // Out valid
  input wire logic [7:0] outData, // Out byte
  input wire logic outSof, // Out first
  input wire logic outEof, // Out last
  input wire logic cellOverflowEvt, // Overflow
  input wire logic cellUnderrunEvt // Underrun
);
  logic [11:0] mode_reg;
  logic [7:0] gap_reg;
  logic [23:0] low_reg;
  logic [23:0] ovhGap;
  logic wrOk;
  assign wrOk = psel && penable && pwrite && pready && !pslverr;
  assign ovhGap = 24'h0C + ((24'(gap_reg) - 24'h0C) << mode_reg[11:8]);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= 12'h0;
      gap_reg <= 8'h0D;
      low_reg <= 24'h0;
    end else begin
      low_reg <= inReady ? 24'h0 : low_reg + 24'h1;
      if (wrOk && paddr == 8'h00) mode_reg <= pwdata[11:0];
      if (wrOk && paddr == 8'h08) gap_reg <= pwdata[7:0];
    end
  end
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  chk_gap_min: assert property (inReady && low_reg != 24'h0 |->
    low_reg >= 24'h0C) else $error("gap too short");
  chk_gap_plain: assert property (inReady && low_reg != 24'h0 &&
    mode_reg[2:0] == 3'h0 |-> low_reg == 24'h0C) else $error("plain gap");
  chk_gap_fixed: assert property (inReady && low_reg != 24'h0 &&
    mode_reg[2:0] == 3'h1 |-> low_reg == ovhGap) else $error("fixed gap");
  chk_stall_eof: assert property ($fell(inReady) |->
    $past(inValid && inEof)) else $error("stall without end");
  chk_pass_byte: assert property (inValid && inReady |=> outValid &&
    outData == $past(inData) && outEof == $past(inEof) &&
    outSof == $past(inSof)) else $error("byte");
  chk_apb_wait: assert property (psel && penable && !pready |=>
    pready) else $error("no answer");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stands");
  chk_err_zero: assert property (pslverr |-> pready &&
    prdata == 32'h0) else $error("error read");
  cover property (pslverr);
  cover property (inReady && low_reg > 24'h0C);
  cover property (wrOk && paddr == 8'h14);
endmodule : trl_checker

// ===== verif/trl_queue_model.sv
`timescale 1ns/10ps
// ----
// Queue-side frame source
// ----
module trl_queue_model (
  input wire logic ref_clk, // Clock
  input wire logic inReady, // Byte taken
  output logic inValid, // Byte valid
  output logic [7:0] inData, // Byte
  output logic inSof, // First byte
  output logic inEof // Last byte
);
  logic [31:0] gap;
  initial begin
    {inValid, inSof, inEof} = 3'h0;
    inData = 8'h0;
  end
  task automatic send(input int n);
    for (int k = 0; k < n; k++) begin
      inValid <= 1'b1;
      inData <= 8'hA5 ^ k[7:0];
      inSof <= k == 0;
      inEof <= k == n - 1;
      do begin
        @(posedge ref_clk);
      end while (!inReady);
    end
    {inValid, inSof, inEof} <= 3'h0;
    inData <= ~inData;
    gap = 32'h0;
    do begin
      @(posedge ref_clk);
      gap += !inReady;
    end while (!inReady);
  endtask : send
endmodule : trl_queue_model

// ===== verif/testbench.sv
`timescale 1ns/10ps
// ----
// Rate limiter bench
// ----
module testbench;
  import trl_pkg::*;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic inValid, inSof, inEof, inReady, outValid, outSof, outEof;
  logic cellOverflowEvt, cellUnderrunEvt;
  logic [7:0] paddr, inData, outData;
  logic [31:0] pwdata, prdata, q, mode;
  int n_mismatch = 0, tests_run = 0, seed = 32'h33DA, hdr, fg, R, st, n, x;
  longint carry = 0;
  trl_rate_limiter i_dut (.*);
  trl_queue_model i_src (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (!pready);
    {q, e} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(posedge ref_clk);
  endtask : apb
  task automatic cmp(input logic [31:0] g, input logic [31:0] w);
    tests_run++;
    if (g !== w) begin
      n_mismatch++;
      $display("wrong value at %0t got %h exp %h", $time, g, w);
    end
  endtask : cmp
  task automatic ev(input logic [7:0] a, input logic v);
    cellOverflowEvt <= v && a == 8'h14;
    cellUnderrunEvt <= v && a == 8'h18;
  endtask : ev
  function automatic int expg(input int n);
    int lp, o, p, f, y;
    longint num;
    lp = n - (mode[5] ? (n < hdr ? n : hdr) : 0) + (mode[4] ? 8 : 0);
    o = mode[0] ? (fg - 12) << mode[11:8] : 0;
    f = st > lp ? st - lp : 0;
    f = mode[2] && f > 12 ? f : 0;
    p = 0;
    if (mode[1]) begin
      num = lp * 256 * (1 << mode[11:8]) + carry;
      p = num / R;
      carry = num % R;
    end
    y = o > p ? o : p;
    y = y > f ? y : f;
    if (mode[3:0] == 4'hB) y = o + p;
    return y;
  endfunction : expg
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    #240000;
    n_mismatch++;
    results;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cellOverflowEvt, cellUnderrunEvt} = 2'h0;
    rst = 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int k = 0; k < 9; k++) begin
      apb(1'b0, k < 8 ? 8'(4 * k) : 8'h24, 32'h0);
      cmp(q, k == 2 ? 32'h0D : k == 3 ? 32'h480 : 32'h0);
      cmp(e, k == 8);
    end
    for (int a = 8'h14; a < 8'h1C; a += 4) begin
      fork
        apb(1'b1, 8'(a), 32'h1);
        begin
          repeat (2) @(posedge ref_clk);
          ev(8'(a), 1'b1);
          @(posedge ref_clk);
          ev(8'(a), 1'b0);
        end
      join
      apb(1'b0, 8'(a), 32'h0);
      cmp(q, 32'h1);
      apb(1'b1, 8'(a), 32'h1);
      apb(1'b0, 8'(a), 32'h0);
      cmp(q, 32'h0);
    end
    for (int i = 0; i < 32; i++) begin
      mode = $random(seed) & 32'h33F;
      if (i < 16) mode[3:0] = i[3:0];
      hdr = {$random(seed)} % 8;
      fg = i == 1 ? 13 : i == 9 ? 255 : 13 + {$random(seed)} % 243;
      R = 1152 + {$random(seed)} % 1000;
      st = {$random(seed)} % 80;
      n = 1 + {$random(seed)} % 40;
      apb(1'b1, 8'h00, mode);
      apb(1'b1, 8'h04, hdr);
      apb(1'b1, 8'h08, fg);
      apb(1'b1, 8'h0C, R);
      apb(1'b1, 8'h10, st);
      x = expg(n);
      i_src.send(n);
      cmp(i_src.gap, 12 + x);
      apb(1'b0, 8'h20, 32'h0);
      cmp(q, x);
      apb(1'b0, 8'h1C, 32'h0);
      cmp(q, x != 0);
      apb(1'b1, 8'h1C, 32'h1);
    end
    results;
  end
endmodule : testbench
bind trl_rate_limiter trl_checker i_chk (.*);
